// ### rtl/tbp_pkg.sv
// Constants, register map and helper functions for the PWM channel pair.
package tbp_pkg;
	localparam int TBP_AW = 12;
	localparam int TBP_DW = 32;
	localparam logic [11:0] TBP_IDX_DUTY6 = 12'h38c;
	localparam logic [11:0] TBP_IDX_CTRL6 = 12'h38e;
	localparam logic [11:0] TBP_IDX_DUTY7 = 12'h390;
	localparam logic [11:0] TBP_IDX_CTRL7 = 12'h392;
	localparam logic [11:0] TBP_IDX_PERIOD = 12'h394;
	localparam logic [11:0] TBP_IDX_TCTRL = 12'h395;
	localparam logic [11:0] TBP_IDX_TSTAT = 12'h396;
	localparam logic [11:0] TBP_IDX_TCOUNT = 12'h397;
	localparam logic [11:0] TBP_IDX_PINDIR = 12'h398;
	localparam int TBP_EN_BIT = 7;
	localparam int TBP_OUT_BIT = 5;
	localparam int TBP_POL_BIT = 4;
	localparam int TBP_DCH_MSB = 15;
	localparam int TBP_DCH_LSB = 8;
	localparam int TBP_DCL_MSB = 7;
	localparam int TBP_DCL_LSB = 6;
	localparam int TBP_RUN_BIT = 2;
	localparam int TBP_FLAG_BIT = 0;
	localparam logic [7:0] TBP_PERIOD_RST = 8'hff;
	localparam logic [1:0] TBP_PINDIR_RST = 2'h3;
	localparam logic [1:0] TBP_PS_RST = 2'h0;
	localparam logic [8:0] TBP_TMR_CLK_DIV = 9'h004;
	typedef logic [9:0] tbp_duty_t;

	// Prescale code 0..3 selects 1, 4, 16 or 64; result is its log2.
	function automatic logic [2:0] tbp_ps_shift(input logic [1:0] ps);
		tbp_ps_shift = {ps, 1'b0};
	endfunction

	// Last system clock of one timer increment.
	function automatic logic [7:0] tbp_div_last(input logic [1:0] ps);
		logic [8:0] span;
		span = TBP_TMR_CLK_DIV << tbp_ps_shift(ps);
		tbp_div_last = 8'(span - 9'h001);
	endfunction

	// Places a 10-bit duty value into its 16-bit register layout.
	function automatic logic [15:0] tbp_duty_word(input tbp_duty_t d);
		tbp_duty_word = {d[9:2], d[1:0], 6'h00};
	endfunction
endpackage

// ### rtl/tbp_timer.sv
// Shared period timer with prescaler and 10-bit time base.
`timescale 1ns/100ps
module tbp_timer (
	input wire logic clk, // system clock
	input wire logic rstn, // async reset, low
	input wire logic sleep, // freezes the timer
	input wire logic run, // timer running
	input wire logic [1:0] prescale, // prescale code
	input wire logic [7:0] period_limit, // period setting
	output logic [7:0] period_timer_count, // timer count
	output logic [9:0] time_base, // 10-bit time base
	output logic wrap // count equals limit at increment
);
	import tbp_pkg::*;
	logic [7:0] div_reg, div_next;
	logic [7:0] cnt_reg, cnt_next;
	logic last;
	logic inc;

	always_comb begin
		div_next = div_reg;
		cnt_next = cnt_reg;
		last = div_reg == tbp_div_last(prescale);
		inc = run & ~sleep & last;
		wrap = inc & (cnt_reg == period_limit);
		if (run & ~sleep) begin
			div_next = last ? 8'h00 : div_reg + 8'h01;
		end
		if (inc) begin
			cnt_next = wrap ? 8'h00 : cnt_reg + 8'h01;
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			div_reg <= 8'h00;
			cnt_reg <= 8'h00;
		end else begin
			div_reg <= div_next;
			cnt_reg <= cnt_next;
		end
	end

	assign period_timer_count = cnt_reg;
	// extended time base
	// The time base shows the value that the coming edge loads, so a duty match clears the output on that edge.
	assign time_base = {cnt_next, 2'(div_next >> tbp_ps_shift(prescale))};

	default clocking @(posedge clk); endclocking
	default disable iff (!rstn);
	chk_sleep_count_hold: assert property (sleep |=> $stable(cnt_reg))
		else $error("timer count moved during sleep");
	chk_wake_resume: assert property ($fell(sleep) |-> cnt_reg == $past(cnt_reg))
		else $error("timer count changed across sleep");
endmodule // tbp_timer

// ### rtl/tbp_chan.sv
// One PWM channel: duty buffer, set/clear logic and polarity.
`timescale 1ns/100ps
module tbp_chan (
	input wire logic clk, // system clock
	input wire logic rstn, // async reset, low
	input wire logic sleep, // freezes channel state
	input wire logic en, // channel enable
	input wire logic invert_output_select, // invert output
	input wire tbp_pkg::tbp_duty_t duty, // written duty value
	input wire logic [9:0] time_base, // shared time base
	input wire logic wrap, // end of period
	output logic level // channel output level
);
	import tbp_pkg::*;
	tbp_duty_t buf_reg, buf_next;
	logic raw_reg, raw_next;
	logic level_reg, level_next;

	always_comb begin
		buf_next = buf_reg;
		raw_next = raw_reg;
		level_next = level_reg;
		if (!sleep) begin
			if (!en) begin
				raw_next = 1'b0;
			end else if (wrap) begin
				buf_next = duty;
				raw_next = duty != 10'h000;
			end else if (time_base == buf_reg) begin
				raw_next = 1'b0;
			end
			level_next = en ? (raw_next ^ invert_output_select) : invert_output_select;
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			buf_reg <= 10'h000;
			raw_reg <= 1'b0;
			level_reg <= 1'b0;
		end else begin
			buf_reg <= buf_next;
			raw_reg <= raw_next;
			level_reg <= level_next;
		end
	end

	assign level = level_reg;

	default clocking @(posedge clk); endclocking
	default disable iff (!rstn);
	chk_sleep_level_hold: assert property (sleep |=> $stable(level_reg) && $stable(buf_reg))
		else $error("channel changed during sleep");
	chk_wrap_buffer_load: assert property (!sleep && en && wrap |=> buf_reg == $past(duty))
		else $error("duty buffer not loaded at period end");
	chk_match_clear: assert property (!sleep && en && !wrap && time_base == buf_reg |=> !raw_reg)
		else $error("output not cleared on duty match");
	chk_disabled_level: assert property (!sleep && !en |=> level_reg == $past(invert_output_select))
		else $error("disabled channel not at idle level");
	chk_wrap_set: assert property (!sleep && en && wrap && duty != 10'h000 |=> raw_reg)
		else $error("output not set at period end");
endmodule // tbp_chan

// ### rtl/tbp_top.sv
// Two PWM channels with shared timer behind an Avalon-MM slave.
//
// The implementer's own choice: the Avalon-MM slave port.
`timescale 1ns/100ps

// Function
// - In sleep the timer count and channel state hold; pins keep level.
// - On wake the timer resumes from its held count.
// - Output frequency scales directly with the system clock.
// - Reset returns channel registers to reset values; pins become inputs.
// - Control bit 7 enables the channel; read/write, resets to 0.
// - Control bit 5 reads the current output level; resets to 0.
// - Control bit 4 inverts the output; resets to 0.
// - Duty upper eight bits in 15:8, lower two bits in 7:6.
// - Duty value undefined at power-on, untouched by other resets.
// - Pin shows the waveform only once its direction is output.
// - Outputs set at each period end unless duty is zero.
// - Output cleared when time base equals buffered duty.
// - Duty is double buffered and loaded at period match.
// - Time base is timer count extended by two lower bits.
module tbp_top (
	input wire logic clk, // system clock, 25 MHz
	input wire logic rstn, // async reset, low
	input wire logic sleep, // device sleep request
	input wire logic [tbp_pkg::TBP_AW-1:0] avs_address, // register index
	input wire logic avs_read, // read request
	input wire logic avs_write, // write request
	input wire logic [tbp_pkg::TBP_DW-1:0] avs_writedata, // write data
	input wire logic [3:0] avs_byteenable, // byte lanes
	output logic [tbp_pkg::TBP_DW-1:0] avs_readdata, // read data
	output logic avs_waitrequest, // slave not ready
	output logic [1:0] pwm_level, // channel outputs to peripherals
	output logic [1:0] pin_out, // pin data
	output logic [1:0] pin_oe, // pin driver enable
	output logic timer_match_flag // period match flag
);
	import tbp_pkg::*;

	logic wait_reg, wait_next;
	logic [31:0] rdata_reg, rdata_next;
	logic [1:0] en_reg, en_next;
	logic [1:0] pol_reg, pol_next;
	tbp_duty_t duty_reg [2];
	tbp_duty_t duty_next [2];
	logic [7:0] period_reg, period_next;
	logic run_reg, run_next;
	logic [1:0] ps_reg, ps_next;
	logic flag_reg, flag_next;
	logic [1:0] dir_reg, dir_next;
	logic [1:0] oe_reg, oe_next;
	logic [1:0] pout_reg, pout_next;
	logic [7:0] tcount;
	logic [9:0] time_base;
	logic wrap;
	logic [1:0] level;
	logic wr;
	logic rd;

	// Bus handshake: one wait cycle, then the answer.
	always_comb begin
		wr = avs_write & ~wait_reg;
		rd = avs_read & wait_reg;
		wait_next = ~((avs_read | avs_write) & wait_reg);
		rdata_next = rdata_reg;
		if (rd) begin
			rdata_next = 32'h0000_0000;
			case (avs_address)
				TBP_IDX_DUTY6: rdata_next[15:0] = tbp_duty_word(duty_reg[0]);
				TBP_IDX_DUTY7: rdata_next[15:0] = tbp_duty_word(duty_reg[1]);
				TBP_IDX_CTRL6: begin
					rdata_next[TBP_EN_BIT] = en_reg[0];
					rdata_next[TBP_OUT_BIT] = level[0];
					rdata_next[TBP_POL_BIT] = pol_reg[0];
				end
				TBP_IDX_CTRL7: begin
					rdata_next[TBP_EN_BIT] = en_reg[1];
					rdata_next[TBP_OUT_BIT] = level[1];
					rdata_next[TBP_POL_BIT] = pol_reg[1];
				end
				TBP_IDX_PERIOD: rdata_next[7:0] = period_reg;
				TBP_IDX_TCTRL: rdata_next[2:0] = {run_reg, ps_reg};
				TBP_IDX_TSTAT: rdata_next[TBP_FLAG_BIT] = flag_reg;
				TBP_IDX_TCOUNT: rdata_next[7:0] = tcount;
				TBP_IDX_PINDIR: rdata_next[1:0] = dir_reg;
				default: rdata_next = 32'h0000_0000;
			endcase
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			wait_reg <= 1'b1;
			rdata_reg <= 32'h0000_0000;
		end else begin
			wait_reg <= wait_next;
			rdata_reg <= rdata_next;
		end
	end

	// Channel control bits.
	always_comb begin
		en_next = en_reg;
		pol_next = pol_reg;
		if (wr && avs_byteenable[0]) begin
			if (avs_address == TBP_IDX_CTRL6) begin
				en_next[0] = avs_writedata[TBP_EN_BIT];
				pol_next[0] = avs_writedata[TBP_POL_BIT];
			end
			if (avs_address == TBP_IDX_CTRL7) begin
				en_next[1] = avs_writedata[TBP_EN_BIT];
				pol_next[1] = avs_writedata[TBP_POL_BIT];
			end
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			en_reg <= 2'h0;
			pol_reg <= 2'h0;
		end else begin
			en_reg <= en_next;
			pol_reg <= pol_next;
		end
	end

	// Duty values, byte lanes 1 and 0.
	always_comb begin
		duty_next = duty_reg;
		for (int g = 0; g < 2; g++) begin
			if (wr && avs_address == (g == 0 ? TBP_IDX_DUTY6 : TBP_IDX_DUTY7)) begin
				if (avs_byteenable[1]) begin
					duty_next[g][9:2] = avs_writedata[TBP_DCH_MSB:TBP_DCH_LSB];
				end
				if (avs_byteenable[0]) begin
					duty_next[g][1:0] = avs_writedata[TBP_DCL_MSB:TBP_DCL_LSB];
				end
			end
		end
	end

	always_ff @(posedge clk) begin
		duty_reg <= duty_next;
	end

	// Timer setup, match flag and pin direction.
	always_comb begin
		period_next = period_reg;
		run_next = run_reg;
		ps_next = ps_reg;
		dir_next = dir_reg;
		flag_next = flag_reg;
		if (wr && avs_byteenable[0]) begin
			case (avs_address)
				TBP_IDX_PERIOD: period_next = avs_writedata[7:0];
				TBP_IDX_TCTRL: begin
					run_next = avs_writedata[TBP_RUN_BIT];
					ps_next = avs_writedata[1:0];
				end
				TBP_IDX_TSTAT: begin
					if (avs_writedata[TBP_FLAG_BIT]) begin
						flag_next = 1'b0;
					end
				end
				TBP_IDX_PINDIR: dir_next = avs_writedata[1:0];
				default: dir_next = dir_reg;
			endcase
		end
		// A match in the clearing cycle keeps the flag set.
		if (wrap) begin
			flag_next = 1'b1;
		end
		oe_next = ~dir_next;
		pout_next = level;
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			period_reg <= TBP_PERIOD_RST;
			run_reg <= 1'b0;
			ps_reg <= TBP_PS_RST;
			flag_reg <= 1'b0;
			dir_reg <= TBP_PINDIR_RST;
			oe_reg <= 2'h0;
			pout_reg <= 2'h0;
		end else begin
			period_reg <= period_next;
			run_reg <= run_next;
			ps_reg <= ps_next;
			flag_reg <= flag_next;
			dir_reg <= dir_next;
			oe_reg <= oe_next;
			pout_reg <= pout_next;
		end
	end

	tbp_timer u_timer (
		.clk(clk),
		.rstn(rstn),
		.sleep(sleep),
		.run(run_reg),
		.prescale(ps_reg),
		.period_limit(period_reg),
		.period_timer_count(tcount),
		.time_base(time_base),
		.wrap(wrap)
	);

	for (genvar g = 0; g < 2; g++) begin : g_chan
		tbp_chan u_chan (
			.clk(clk),
			.rstn(rstn),
			.sleep(sleep),
			.en(en_reg[g]),
			.invert_output_select(pol_reg[g]),
			.duty(duty_reg[g]),
			.time_base(time_base),
			.wrap(wrap),
			.level(level[g])
		);
	end

	assign avs_waitrequest = wait_reg;
	assign avs_readdata = rdata_reg;
	assign pwm_level = level;
	assign pin_out = pout_reg;
	assign pin_oe = oe_reg;
	assign timer_match_flag = flag_reg;

	default clocking @(posedge clk); endclocking
	default disable iff (!rstn);
	sequence s_req_waiting;
		(avs_read || avs_write) && avs_waitrequest;
	endsequence
	sequence s_answer;
		!avs_waitrequest ##1 avs_waitrequest;
	endsequence
	chk_bus_answer: assert property (s_req_waiting |=> s_answer)
		else $error("bus answer not given after one wait cycle");
	chk_enable_write: assert property (wr && avs_byteenable[0] && avs_address == TBP_IDX_CTRL6
		|=> en_reg[0] == $past(avs_writedata[TBP_EN_BIT]))
		else $error("enable bit not written");
	chk_out_readback: assert property (rd && avs_address == TBP_IDX_CTRL7
		|=> avs_readdata[TBP_OUT_BIT] == $past(level[1]))
		else $error("output level bit reads wrong");
	chk_pin_direction: assert property (wr && avs_byteenable[0] && avs_address == TBP_IDX_PINDIR
		|=> pin_oe == ~$past(avs_writedata[1:0]))
		else $error("pin enable does not follow direction");
	chk_flag_set: assert property (wrap |=> timer_match_flag)
		else $error("match flag not set at period end");
	chk_pin_sleep_hold: assert property (sleep ##1 sleep |=> $stable(pin_out))
		else $error("pin level moved during sleep");
	// Write requests that the register checks below start from.
	sequence s_ctrl6_write;
		wr && avs_byteenable[0] && avs_address == TBP_IDX_CTRL6;
	endsequence
	sequence s_ctrl7_write;
		wr && avs_byteenable[0] && avs_address == TBP_IDX_CTRL7;
	endsequence
	sequence s_duty6_upper;
		wr && avs_byteenable[1] && avs_address == TBP_IDX_DUTY6;
	endsequence
	sequence s_duty6_lower;
		wr && avs_byteenable[0] && avs_address == TBP_IDX_DUTY6;
	endsequence
	chk_polarity_write: assert property (s_ctrl6_write
		|=> pol_reg[0] == $past(avs_writedata[TBP_POL_BIT]))
		else $error("polarity bit not written");
	chk_ch7_enable_write: assert property (s_ctrl7_write
		|=> en_reg[1] == $past(avs_writedata[TBP_EN_BIT]))
		else $error("channel 7 enable bit not written");
	chk_ch7_polarity_write: assert property (s_ctrl7_write
		|=> pol_reg[1] == $past(avs_writedata[TBP_POL_BIT]))
		else $error("channel 7 polarity bit not written");
	chk_duty_upper_write: assert property (s_duty6_upper
		|=> duty_reg[0][9:2] == $past(avs_writedata[TBP_DCH_MSB:TBP_DCH_LSB]))
		else $error("duty upper bits not written");
	chk_duty_lower_write: assert property (s_duty6_lower
		|=> duty_reg[0][1:0] == $past(avs_writedata[TBP_DCL_MSB:TBP_DCL_LSB]))
		else $error("duty lower bits not written");
	chk_duty_readback: assert property (rd && avs_address == TBP_IDX_DUTY6
		|=> avs_readdata[15:0] == {$past(duty_reg[0]), 6'h00})
		else $error("duty register reads wrong");
	chk_out6_readback: assert property (rd && avs_address == TBP_IDX_CTRL6
		|=> avs_readdata[TBP_OUT_BIT] == $past(level[0]))
		else $error("channel 6 output level bit reads wrong");
	chk_pin_data_follow: assert property (1'b1 |=> pin_out == $past(level))
		else $error("pin data does not follow channel level");
endmodule // tbp_top

// ### bench/tbp_pin_model.sv
// Pad model standing at the far side of the two channel pins.
`timescale 1ns/100ps
module tbp_pin_model (
	input wire logic clk, // system clock
	input wire logic rstn, // async reset, low
	input wire logic [1:0] pin_out, // pin data from the block
	input wire logic [1:0] pin_oe, // pin driver enable
	output logic [1:0] pad // level seen on the pads
);
	logic float_reg;
	logic float_next;
	// Pads have no pull, so an undriven pad flips every cycle instead of holding.
	always_comb begin
		float_next = ~float_reg;
	end
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			float_reg <= 1'b0;
		end else begin
			float_reg <= float_next;
		end
	end
	always_comb begin
		pad = (pin_oe & pin_out) | (~pin_oe & {float_reg, ~float_reg});
	end
endmodule // tbp_pin_model

// ### bench/tbp_top_test.sv
// Self-checking bench for the PWM channel pair.
`timescale 1ns/100ps
module tbp_top_test;
	import tbp_pkg::*;
	logic clk = 1'b0;
	logic rstn = 1'b0;
	logic sleep = 1'b0;
	logic [11:0] avs_address = 12'h000;
	logic avs_read = 1'b0;
	logic avs_write = 1'b0;
	logic [31:0] avs_writedata = 32'h0;
	logic [3:0] avs_byteenable = 4'hf;
	logic [31:0] avs_readdata;
	logic avs_waitrequest;
	logic [1:0] pwm_level;
	logic [1:0] pin_out;
	logic [1:0] pin_oe;
	logic [1:0] pad;
	logic timer_match_flag;
	logic [31:0] v;
	logic [31:0] c1;
	logic [1:0] lv;
	logic pd;
	int err_total = 0;
	int cmp_count = 0;
	int h;

	always #20 clk = ~clk;

	tbp_top u_tbp_top (.clk(clk), .rstn(rstn), .sleep(sleep), .avs_address(avs_address),
		.avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
		.pwm_level(pwm_level), .pin_out(pin_out), .pin_oe(pin_oe), .timer_match_flag(timer_match_flag));

	tbp_pin_model u_tbp_pin_model (.clk(clk), .rstn(rstn), .pin_out(pin_out), .pin_oe(pin_oe), .pad(pad));

	task automatic results;
		$display("comparisons %0d, mismatches %0d", cmp_count, err_total);
		if (err_total == 0 && cmp_count > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			err_total++;
			$display("unexpected at %0t: saw %h, expected %h", $time, seen, exp);
		end
	endtask

	// One bus transfer; the request stands until waitrequest is seen low.
	task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] d);
		int n;
		n = 0;
		avs_address <= a;
		avs_writedata <= d;
		avs_read <= !wr;
		avs_write <= wr;
		do begin
			@(posedge clk);
			n++;
		end while (avs_waitrequest !== 1'b0 && n < 50);
		chk({31'h0, avs_waitrequest}, 32'h0);
		v = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
		@(posedge clk);
	endtask

	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		xfer(1'b1, a, d);
	endtask

	task automatic rd(input logic [11:0] a);
		xfer(1'b0, a, 32'h0);
	endtask

	function automatic logic [31:0] dw(input logic [9:0] d);
		dw = {16'h0, d[9:2], d[1:0], 6'h00};
	endfunction

	// Counts high samples of a level (s=0) or a pad (s=1) over n cycles.
	task automatic cnt(input int s, input int ch, input int n);
		h = 0;
		repeat (n) begin
			@(posedge clk);
			if ((s != 0 ? pad[ch] : pwm_level[ch]) === 1'b1) h++;
		end
	endtask

	// Waits for the next rising edge of a channel; h holds the cycles waited.
	task automatic rise(input int ch);
		logic p;
		p = 1'b1;
		h = 0;
		while (!(p === 1'b0 && pwm_level[ch] === 1'b1) && h < 2000) begin
			p = pwm_level[ch];
			@(posedge clk);
			h++;
		end
	endtask

	initial begin
		repeat (4) @(posedge clk);
		rstn <= 1'b1;
		@(posedge clk);
		rd(TBP_IDX_CTRL6);
		chk({24'h0, v[7:0]}, 32'h0);
		rd(TBP_IDX_CTRL7);
		chk({24'h0, v[7:0]}, 32'h0);
		chk({30'h0, pin_oe}, 32'h0);
		rd(TBP_IDX_PINDIR);
		chk({30'h0, v[1:0]}, 32'h3);
		wr(TBP_IDX_PINDIR, 32'h3);
		wr(TBP_IDX_CTRL6, 32'h0);
		wr(TBP_IDX_CTRL7, 32'h0);
		wr(TBP_IDX_PERIOD, 32'h3);
		wr(TBP_IDX_DUTY6, dw(10'd8));
		wr(TBP_IDX_DUTY7, dw(10'h2c6));
		rd(TBP_IDX_DUTY7);
		chk({22'h0, v[15:6]}, 32'h2c6);
		// Upper lane alone: bits 9:2 change, bits 1:0 keep their old value.
		avs_byteenable <= 4'h2;
		wr(TBP_IDX_DUTY7, dw(10'h004));
		avs_byteenable <= 4'hf;
		rd(TBP_IDX_DUTY7);
		chk({22'h0, v[15:6]}, 32'h006);
		wr(TBP_IDX_DUTY7, dw(10'd0));
		wr(12'h3a0, 32'hffffffff);
		rd(12'h3a0);
		chk(v, 32'h0);
		wr(TBP_IDX_CTRL6, 32'h7f);
		rd(TBP_IDX_CTRL6);
		chk(v & 32'hb0, 32'h30);
		chk({31'h0, pwm_level[0]}, 32'h1);
		wr(TBP_IDX_CTRL6, 32'h20);
		rd(TBP_IDX_CTRL6);
		chk(v & 32'hb0, 32'h0);
		chk({31'h0, pwm_level[0]}, 32'h0);
		wr(TBP_IDX_TSTAT, 32'h1);
		wr(TBP_IDX_TCTRL, 32'h4);
		h = 0;
		while (timer_match_flag !== 1'b1 && h < 100) begin
			@(posedge clk);
			h++;
		end
		chk({31'h0, timer_match_flag}, 32'h1);
		wr(TBP_IDX_PINDIR, 32'h2);
		@(posedge clk);
		chk({30'h0, pin_oe}, 32'h1);
		wr(TBP_IDX_CTRL6, 32'h80);
		wr(TBP_IDX_CTRL7, 32'h80);
		rise(0);
		fork
			wr(TBP_IDX_DUTY6, dw(10'd12));
			cnt(0, 0, 16);
		join
		chk(h, 8);
		cnt(0, 0, 16);
		chk(h, 12);
		cnt(0, 1, 16);
		chk(h, 0);
		cnt(1, 0, 16);
		chk(h, 12);
		wr(TBP_IDX_DUTY7, dw(10'd16));
		repeat (20) @(posedge clk);
		cnt(0, 1, 16);
		chk(h, 16);
		wr(TBP_IDX_CTRL6, 32'h90);
		repeat (2) @(posedge clk);
		cnt(0, 0, 16);
		chk(h, 4);
		wr(TBP_IDX_TCTRL, 32'h5);
		rise(0);
		rise(0);
		chk(h, 64);
		cnt(0, 0, 64);
		chk(h, 16);
		wr(TBP_IDX_TCTRL, 32'h7);
		repeat (600) @(posedge clk);
		sleep <= 1'b1;
		repeat (3) @(posedge clk);
		lv = pwm_level;
		pd = pad[0];
		rd(TBP_IDX_TCOUNT);
		c1 = v;
		repeat (300) @(posedge clk);
		rd(TBP_IDX_TCOUNT);
		chk(v, c1);
		chk({30'h0, pwm_level}, {30'h0, lv});
		chk({31'h0, pad[0]}, {31'h0, pd});
		sleep <= 1'b0;
		@(posedge clk);
		rd(TBP_IDX_TCOUNT);
		chk({31'h0, v === c1 || v === ((c1 + 32'h1) & 32'h3)}, 32'h1);
		rstn <= 1'b0;
		repeat (4) @(posedge clk);
		rstn <= 1'b1;
		@(posedge clk);
		chk({30'h0, pin_oe}, 32'h0);
		rd(TBP_IDX_CTRL6);
		chk({24'h0, v[7:0]}, 32'h0);
		rd(TBP_IDX_DUTY6);
		chk({22'h0, v[15:6]}, 32'd12);
		results;
	end

	initial begin
		repeat (10000) @(posedge clk);
		err_total++;
		results;
	end
endmodule // tbp_top_test
